// file: hw/cfg_reg_store.sv
// register file storage: single write port, registered read port
module cfg_reg_store #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32,
	parameter int AW = 5
) (
	// clock
	input wire logic i_mclk,
	// write port
	input wire logic i_we,
	input wire logic [AW-1:0] i_waddr,
	input wire logic [WIDTH-1:0] i_wdata,
	// read port
	input wire logic i_re,
	input wire logic [AW-1:0] i_raddr,
	output logic [WIDTH-1:0] o_rdata
);

	logic [WIDTH-1:0] mem_r [DEPTH];

	// contents are not reset: software configures them after power-up
	always_ff @(posedge i_mclk)
	begin
		if (i_we)
		begin
			mem_r[i_waddr] <= i_wdata;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_re)
		begin
			o_rdata <= mem_r[i_raddr];
		end
	end

endmodule : cfg_reg_store

// file: hw/serial_config_port_status.sv
// serial config port, status pin mux, lock detector and avalon slave
//
// Behaviour
// - unlock flag selectable onto either status output
// - unlock pin level is inverse of register bit
// - several selects on one output are OR-ed
// - digital slip counter asserts unlock past threshold
// - large error holds unlock, medium error toggles
// - tiny error gives rare thousand-cycle low excursions
// - mode pins pick serial, two-wire or pin
// - pin mode takes setup from five pins
// - writes to read-only bits change nothing
// - twenty-one 16-bit registers at addresses 0 to 20, status at 21
// - message: direction, 4 fixed, 11 address, 16 data
// - select low starts, data sampled rising clock
// - first bit 1 means read, 0 write
// - early select high aborts with no change
// - read data driven for 16 clocks after header
// - serial output released while select high
// - select held low auto-increments address per word
// - reference-selection flag routable to either output
// - reference-loss flag routable to either output
// - register 3 bits 12..7 hold event selects
package scp_pkg;
	localparam int REG_W = 16;
	localparam int AW = 5;
	localparam int PTR_W = 11;
	localparam logic [PTR_W-1:0] NUM_REGS = 11'h015;
	localparam logic [PTR_W-1:0] STAT_REG = 11'h015;
	localparam logic [PTR_W-1:0] SEL_REG = 11'h003;
	localparam int UNLOCK_BIT = 2;
	localparam int SEL_A_REF = 12;
	localparam int SEL_A_LOSS = 11;
	localparam int SEL_A_UNLK = 10;
	localparam int SEL_B_REF = 9;
	localparam int SEL_B_LOSS = 8;
	localparam int SEL_B_UNLK = 7;
	localparam int DIR_POS = 15;
	localparam logic [3:0] LAST_BIT = 4'hf;
	localparam logic [1:0] MODE_SPI = 2'h0;
	localparam logic [1:0] MODE_I2C = 2'h1;
	localparam logic [1:0] MODE_PIN = 2'h2;
	localparam logic [3:0] AV_CTRL = 4'h0;
	localparam logic [3:0] AV_STAT = 4'h4;
	localparam logic [7:0] SLIP_THR_RST = 8'h04;
	localparam logic [9:0] HOLD_PFD = 10'h3e8;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_HDR = 4'h2,
		ST_WDATA = 4'h4,
		ST_RDATA = 4'h8
	} port_state_t;
endpackage : scp_pkg

module serial_config_port_status
	import scp_pkg::*;
(
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rstn,
	// serial port pins
	input wire logic i_serial_clk,
	input wire logic i_serial_select_n,
	input wire logic i_serial_in,
	output logic o_serial_out,
	output logic o_serial_out_oe,
	// mode and configuration pins
	input wire logic [1:0] i_host_mode,
	input wire logic [4:0] i_config_select_pins,
	output logic o_spi_sel,
	output logic o_i2c_sel,
	output logic o_pin_mode,
	output logic [4:0] o_preset_sel,
	// loop monitors
	input wire logic i_pfd_ref,
	input wire logic i_pfd_fb,
	input wire logic i_ref_loss_flag,
	input wire logic i_ref_sec_sel,
	// status pins
	output logic o_flag_out_a,
	output logic o_flag_out_b,
	// avalon-mm slave
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [9:0] sync1_r;
	logic [9:0] sync2_r;
	logic [4:0] cfg1_r;
	logic [4:0] cfg2_r;
	logic sclk_d_r;
	logic ref_d_r;
	logic fb_d_r;

	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
		begin
			sync1_r <= 10'h001;
			sync2_r <= 10'h001;
			cfg1_r <= 5'h00;
			cfg2_r <= 5'h00;
			sclk_d_r <= 1'b0;
			ref_d_r <= 1'b0;
			fb_d_r <= 1'b0;
		end
		else
		begin
			sync1_r <= {i_host_mode, i_ref_sec_sel, i_ref_loss_flag,
				i_pfd_fb, i_pfd_ref, i_serial_in, i_serial_clk,
				1'b0, i_serial_select_n};
			sync2_r <= sync1_r;
			cfg1_r <= i_config_select_pins;
			cfg2_r <= cfg1_r;
			sclk_d_r <= sync2_r[2];
			ref_d_r <= sync2_r[4];
			fb_d_r <= sync2_r[5];
		end
	end

	logic cs_n;
	logic sclk;
	logic serial_in;
	logic ref_loss;
	logic ref_sec;
	logic [1:0] mode;
	logic sclk_rise;
	logic sclk_fall;
	logic ref_edge;
	logic fb_edge;

	assign cs_n = sync2_r[0];
	assign sclk = sync2_r[2];
	assign serial_in = sync2_r[3];
	assign ref_loss = sync2_r[6];
	assign ref_sec = sync2_r[7];
	assign mode = sync2_r[9:8];
	assign sclk_rise = sclk & ~sclk_d_r;
	assign sclk_fall = ~sclk & sclk_d_r;
	assign ref_edge = sync2_r[4] & ~ref_d_r;
	assign fb_edge = sync2_r[5] & ~fb_d_r;

	// ----------------------------------------------------------------
	// mode selection
	// ----------------------------------------------------------------
	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
		begin
			o_spi_sel <= 1'b0;
			o_i2c_sel <= 1'b0;
			o_pin_mode <= 1'b0;
			o_preset_sel <= 5'h00;
		end
		else
		begin
			o_spi_sel <= (mode == MODE_SPI);
			o_i2c_sel <= (mode == MODE_I2C);
			o_pin_mode <= (mode == MODE_PIN);
			// presets follow the pins only in standalone mode
			if (mode == MODE_PIN)
			begin
				o_preset_sel <= cfg2_r;
			end
		end
	end

	// ----------------------------------------------------------------
	// serial port state machine
	// ----------------------------------------------------------------
	port_state_t state_r;
	logic [3:0] cnt_r;
	logic [14:0] hdr_r;
	logic [REG_W-1:0] wsh_r;
	logic [REG_W-1:0] osh_r;
	logic [PTR_W-1:0] ptr_r;
	logic rd_req_r;
	logic rd_load_r;
	logic out_r;
	logic oe_r;
	logic [REG_W-1:0] sel_r;
	logic [REG_W-1:0] mem_q;
	logic mem_we;
	logic unlock_r;
	logic [REG_W-1:0] stat_word;
	logic [REG_W-1:0] hdr_full;
	logic abort;

	function automatic logic writable(input logic [PTR_W-1:0] a);
		writable = (a < NUM_REGS);
	endfunction : writable

	assign hdr_full = {hdr_r, serial_in};
	// select high at any point drops the message; the word in progress is not committed
	assign abort = cs_n || (mode != MODE_SPI);
	assign mem_we = (state_r == ST_WDATA) && !abort && sclk_rise &&
		(cnt_r == LAST_BIT) && writable(ptr_r);
	assign stat_word = {{(REG_W-UNLOCK_BIT-1){1'b0}}, unlock_r,
		{UNLOCK_BIT{1'b0}}};

	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
		begin
			state_r <= ST_IDLE;
			cnt_r <= 4'h0;
			hdr_r <= 15'h0000;
			wsh_r <= 16'h0000;
			ptr_r <= 11'h000;
			rd_req_r <= 1'b0;
		end
		else
		begin
			rd_req_r <= 1'b0;
			if (abort)
			begin
				state_r <= ST_IDLE;
				cnt_r <= 4'h0;
			end
			else
			begin
				unique case (state_r)
				ST_IDLE:
				begin
					state_r <= ST_HDR;
					cnt_r <= 4'h0;
				end
				ST_HDR:
				begin
					if (sclk_rise)
					begin
						hdr_r <= hdr_full[14:0];
						cnt_r <= cnt_r + 4'h1;
						if (cnt_r == LAST_BIT)
						begin
							// fixed bits are not checked
							ptr_r <= hdr_full[PTR_W-1:0];
							if (hdr_full[DIR_POS])
							begin
								state_r <= ST_RDATA;
								rd_req_r <= 1'b1;
							end
							else
							begin
								state_r <= ST_WDATA;
							end
						end
					end
				end
				ST_WDATA:
				begin
					if (sclk_rise)
					begin
						wsh_r <= {wsh_r[14:0], serial_in};
						cnt_r <= cnt_r + 4'h1;
						if (cnt_r == LAST_BIT)
						begin
							ptr_r <= ptr_r + 11'h001;
						end
					end
				end
				ST_RDATA:
				begin
					if (sclk_rise)
					begin
						cnt_r <= cnt_r + 4'h1;
						if (cnt_r == LAST_BIT)
						begin
							ptr_r <= ptr_r + 11'h001;
							rd_req_r <= 1'b1;
						end
					end
				end
				endcase
			end
		end
	end

	// register 3 shadow keeps event selects live for the pin mux
	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
		begin
			sel_r <= 16'h0000;
		end
		else if (mem_we && ptr_r == SEL_REG)
		begin
			sel_r <= {wsh_r[14:0], serial_in};
		end
	end

	cfg_reg_store #(
		.WIDTH(REG_W),
		.DEPTH(32),
		.AW(AW)
	) u_store (
		.i_mclk(i_mclk),
		.i_we(mem_we),
		.i_waddr(ptr_r[AW-1:0]),
		.i_wdata({wsh_r[14:0], serial_in}),
		.i_re(rd_req_r),
		.i_raddr(ptr_r[AW-1:0]),
		.o_rdata(mem_q)
	);

	// ----------------------------------------------------------------
	// read data shifter
	// ----------------------------------------------------------------
	// load lands one mclk cycle before the synchronised falling edge at the bench rate
	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
		begin
			rd_load_r <= 1'b0;
			osh_r <= 16'h0000;
			out_r <= 1'b0;
			oe_r <= 1'b0;
		end
		else
		begin
			rd_load_r <= rd_req_r;
			oe_r <= (state_r == ST_RDATA) && !abort;
			if (rd_load_r)
			begin
				if (ptr_r == STAT_REG)
				begin
					osh_r <= stat_word;
				end
				else if (writable(ptr_r))
				begin
					osh_r <= mem_q;
				end
				else
				begin
					osh_r <= 16'h0000;
				end
			end
			else if (sclk_fall && state_r == ST_RDATA && !abort)
			begin
				out_r <= osh_r[REG_W-1];
				osh_r <= {osh_r[14:0], 1'b0};
			end
		end
	end

	assign o_serial_out = out_r;
	assign o_serial_out_oe = oe_r;

	// ----------------------------------------------------------------
	// lock detector
	// ----------------------------------------------------------------
	logic [1:0] lead_r;
	logic [7:0] slips_r;
	logic [9:0] hold_r;
	logic [7:0] thr_r;
	logic slip;

	// lead counts unmatched edges; a second one in a row is a slip
	assign slip = (ref_edge && !fb_edge && lead_r == 2'h1) ||
		(fb_edge && !ref_edge && lead_r == 2'h3);

	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
		begin
			lead_r <= 2'h0;
		end
		else if (ref_edge && !fb_edge && lead_r != 2'h1)
		begin
			lead_r <= lead_r + 2'h1;
		end
		else if (fb_edge && !ref_edge && lead_r != 2'h3)
		begin
			lead_r <= lead_r - 2'h1;
		end
	end

	// a long hold filters single slips into one bounded excursion
	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
		begin
			slips_r <= 8'h00;
			hold_r <= 10'h000;
			unlock_r <= 1'b0;
		end
		else if (slip && slips_r >= thr_r)
		begin
			unlock_r <= 1'b1;
			hold_r <= HOLD_PFD;
			slips_r <= 8'h00;
		end
		else
		begin
			if (slip)
			begin
				slips_r <= slips_r + 8'h01;
			end
			if (ref_edge && hold_r != 10'h000)
			begin
				hold_r <= hold_r - 10'h001;
			end
			else if (hold_r == 10'h000)
			begin
				unlock_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// status pin mux
	// ----------------------------------------------------------------
	// loss flag passes unfiltered, so a stuck loss engine shows here
	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
		begin
			o_flag_out_a <= 1'b0;
			o_flag_out_b <= 1'b0;
		end
		else
		begin
			o_flag_out_a <= (sel_r[SEL_A_REF] & ref_sec) |
				(sel_r[SEL_A_LOSS] & ref_loss) |
				(sel_r[SEL_A_UNLK] & ~unlock_r);
			o_flag_out_b <= (sel_r[SEL_B_REF] & ref_sec) |
				(sel_r[SEL_B_LOSS] & ref_loss) |
				(sel_r[SEL_B_UNLK] & ~unlock_r);
		end
	end

	// ----------------------------------------------------------------
	// avalon slave
	// ----------------------------------------------------------------
	logic ack_r;

	assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_r;

	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
		begin
			ack_r <= 1'b0;
			thr_r <= SLIP_THR_RST;
			o_avs_readdata <= 32'h00000000;
		end
		else
		begin
			ack_r <= (i_avs_read | i_avs_write) & ~ack_r;
			if (i_avs_write && !ack_r && i_avs_address == AV_CTRL)
			begin
				thr_r <= i_avs_writedata[7:0];
			end
			if (i_avs_read && !ack_r)
			begin
				unique case (i_avs_address)
				AV_CTRL: o_avs_readdata <= {24'h000000, thr_r};
				AV_STAT: o_avs_readdata <= {21'h000000, state_r != ST_IDLE,
					cfg2_r, mode, ref_sec, ref_loss, unlock_r};
				default: o_avs_readdata <= 32'h00000000;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);

	sequence s_rd_issue;
		rd_req_r && !abort;
	endsequence
	sequence s_rd_loaded;
		##1 rd_load_r ##1 !rd_load_r;
	endsequence

	chk_flag_a_mux: assert property (
		##1 o_flag_out_a == (($past(sel_r[SEL_A_REF]) & $past(ref_sec)) |
		($past(sel_r[SEL_A_LOSS]) & $past(ref_loss)) |
		($past(sel_r[SEL_A_UNLK]) & ~$past(unlock_r))))
		else $error("flag a not the or of enabled events");
	chk_unlock_pin_inv: assert property (
		(sel_r[SEL_B_UNLK] && !sel_r[SEL_B_REF] && !sel_r[SEL_B_LOSS] &&
		unlock_r) |=> !o_flag_out_b)
		else $error("unlock must drive status pin low");
	chk_oe_released: assert property (
		cs_n |=> !o_serial_out_oe)
		else $error("serial out driven while deselected");
	chk_write_complete: assert property (
		mem_we |-> (cnt_r == LAST_BIT && state_r == ST_WDATA && !cs_n))
		else $error("write before full payload");
	chk_ro_protect: assert property (
		mem_we |-> ptr_r < NUM_REGS)
		else $error("write reached read-only register");
	chk_block_incr: assert property (
		mem_we |=> ptr_r == $past(ptr_r) + 11'h001)
		else $error("address pointer did not advance");
	chk_dir_read: assert property (
		(state_r == ST_HDR && sclk_rise && !abort && cnt_r == LAST_BIT &&
		hdr_r[DIR_POS-1]) |=> state_r == ST_RDATA)
		else $error("direction bit misread");
	chk_rd_fetch: assert property (
		s_rd_issue |-> s_rd_loaded)
		else $error("read data not loaded in two cycles");
	chk_unlock_hold: assert property (
		$rose(unlock_r) |-> hold_r == HOLD_PFD)
		else $error("unlock hold not started");
	chk_abort_idle: assert property (
		abort |=> state_r == ST_IDLE ##0 !mem_we)
		else $error("transfer not aborted");
	chk_mode_gate: assert property (
		state_r != ST_IDLE |-> $past(mode) == MODE_SPI)
		else $error("serial port active outside serial mode");

endmodule : serial_config_port_status

// file: test/serial_host_model.sv
// behavioural serial host that frames messages onto the config port
module serial_host_model (
	// serial pins
	output logic o_sclk,
	output logic o_sel_n,
	output logic o_sdi,
	input wire logic i_sdo
);
	timeunit 1ns;
	timeprecision 100ps;

	initial
	begin
		o_sclk = 1'b0;
		o_sel_n = 1'b1;
		o_sdi = 1'b0;
	end

	// ------------------------------------------------------------
	// one frame: header, data words, early abort when n is short
	// ------------------------------------------------------------
	// the clock is idle low between frames and runs off the mclk grid
	task automatic xfer(input logic rd, input logic [10:0] a,
		input logic [63:0] d, input int n, output logic [63:0] q);
		logic [79:0] sh;
		sh = {rd, 4'h0, a, d};
		q = 64'h0;
		#13 o_sel_n = 1'b0;
		for (int k = 0; k < n; k++)
		begin
			o_sdi = sh[79-k];
			#200;
			if (k > 15)
				q = {q[62:0], i_sdo};
			o_sclk = 1'b1;
			#120 o_sclk = 1'b0;
		end
		#200 o_sel_n = 1'b1;
		o_sdi = ~o_sdi;
		#400;
	endtask : xfer
endmodule : serial_host_model

// file: test/test_serial_config_port_status.sv
// self-checking bench for the serial config port and status block
module test_serial_config_port_status;
	import scp_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;

	logic i_mclk = 1'b0;
	logic i_rstn = 1'b0;
	logic i_serial_clk, i_serial_select_n, i_serial_in;
	logic o_serial_out, o_serial_out_oe;
	logic [1:0] i_host_mode = 2'h0;
	logic [4:0] i_config_select_pins = 5'h00;
	logic o_spi_sel, o_i2c_sel, o_pin_mode;
	logic [4:0] o_preset_sel;
	logic i_pfd_ref = 1'b0;
	logic i_pfd_fb = 1'b0;
	logic i_ref_loss_flag = 1'b0;
	logic i_ref_sec_sel = 1'b0;
	logic o_flag_out_a, o_flag_out_b;
	logic [3:0] i_avs_address = 4'h0;
	logic i_avs_read = 1'b0;
	logic i_avs_write = 1'b0;
	logic [31:0] i_avs_writedata = 32'h0;
	logic [31:0] o_avs_readdata;
	logic o_avs_waitrequest;
	logic sdo_last = 1'b0;
	logic [63:0] r;
	logic [31:0] v;
	logic [9:0] e;
	// {selects a then b, ref secondary, ref lost, flag a, flag b}
	logic [9:0] tbl [6] = '{10'h22a, 10'h225, 10'h082, 10'h011,
		10'h306, 10'h00c};
	int err_count = 0;
	int num_checks = 0;
	// released line shows the inverse, so a stale bit never passes
	wire logic sdo_line = o_serial_out_oe ? o_serial_out : ~sdo_last;

	always #20 i_mclk = ~i_mclk;
	always @(posedge i_mclk)
		if (o_serial_out_oe)
			sdo_last <= o_serial_out;

	serial_config_port_status dut (.i_mclk, .i_rstn, .i_serial_clk,
		.i_serial_select_n, .i_serial_in, .o_serial_out,
		.o_serial_out_oe, .i_host_mode, .i_config_select_pins,
		.o_spi_sel, .o_i2c_sel, .o_pin_mode, .o_preset_sel, .i_pfd_ref,
		.i_pfd_fb, .i_ref_loss_flag, .i_ref_sec_sel, .o_flag_out_a,
		.o_flag_out_b, .i_avs_address, .i_avs_read, .i_avs_write,
		.i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest);
	serial_host_model host (.o_sclk(i_serial_clk),
		.o_sel_n(i_serial_select_n), .o_sdi(i_serial_in),
		.i_sdo(sdo_line));

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
			err_count++;
		end
	endtask : check

	task automatic av(input logic wr, input logic [3:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge i_mclk);
		i_avs_address <= a;
		i_avs_writedata <= d;
		i_avs_write <= wr;
		i_avs_read <= !wr;
		n = 0;
		do
		begin
			@(posedge i_mclk);
			n++;
		end
		while (o_avs_waitrequest !== 1'b0 && n < 20);
		if (n == 20)
			err_count++;
		q = o_avs_readdata;
		i_avs_write <= 1'b0;
		i_avs_read <= 1'b0;
	endtask : av

	task results;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : results

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial
	begin
		repeat (16) @(posedge i_mclk);
		i_rstn <= 1'b1;
		repeat (4) @(posedge i_mclk);
		check(o_serial_out_oe, 32'h0);
		av(1'b0, AV_CTRL, 32'h0, v);
		check(v, 32'h4);
		av(1'b1, 4'h8, 32'hff, v);
		av(1'b0, 4'h8, 32'h0, v);
		check(v, 32'h0);
		av(1'b1, AV_CTRL, 32'h2, v);
		av(1'b0, AV_CTRL, 32'h0, v);
		check(v, 32'h2);
		host.xfer(1'b0, 11'h005, {16'ha5c3, 48'h0}, 32, r);
		host.xfer(1'b1, 11'h005, 64'h0, 32, r);
		check(r[15:0], 16'ha5c3);
		check(o_serial_out_oe, 32'h0);
		host.xfer(1'b0, 11'h005, {16'h1234, 48'h0}, 31, r);
		host.xfer(1'b1, 11'h005, 64'h0, 32, r);
		check(r[15:0], 16'ha5c3);
		host.xfer(1'b0, 11'h006, {32'h0f0e7001, 32'h0}, 48, r);
		host.xfer(1'b1, 11'h006, 64'h0, 48, r);
		check(r[31:0], 32'h0f0e7001);
		// block write runs from the last writable register into status
		host.xfer(1'b0, 11'h014, {32'hbeefffff, 32'h0}, 48, r);
		host.xfer(1'b1, 11'h014, 64'h0, 48, r);
		check(r[31:16], 16'hbeef);
		check(r[15:0] & 16'h0004, 16'h0);
		host.xfer(1'b1, 11'h016, 64'h0, 32, r);
		check(r[15:0], 16'h0);
		// several selects set on purpose to see the or of flags
		foreach (tbl[k])
		begin
			e = tbl[k];
			host.xfer(1'b0, SEL_REG, {3'h0, e[9:4], 7'h00, 48'h0}, 32, r);
			@(posedge i_mclk);
			i_ref_sec_sel <= e[3];
			i_ref_loss_flag <= e[2];
			repeat (8) @(posedge i_mclk);
			check({o_flag_out_a, o_flag_out_b}, e[1:0]);
		end
		host.xfer(1'b0, SEL_REG, {16'h0480, 48'h0}, 32, r);
		@(posedge i_mclk);
		i_ref_sec_sel <= 1'b0;
		i_ref_loss_flag <= 1'b0;
		repeat (8) @(posedge i_mclk);
		check(o_flag_out_a, 32'h1);
		check(o_flag_out_b, 32'h1);
		// reference edges with a stalled feedback are slips after the first
		repeat (40)
		begin
			repeat (4) @(posedge i_mclk);
			i_pfd_ref <= ~i_pfd_ref;
		end
		repeat (8) @(posedge i_mclk);
		check(o_flag_out_a, 32'h0);
		check(o_flag_out_b, 32'h0);
		av(1'b0, AV_STAT, 32'h0, v);
		check(v & 32'h1, 32'h1);
		host.xfer(1'b1, STAT_REG, 64'h0, 32, r);
		check(r[15:0] & 16'h0004, 16'h0004);
		@(posedge i_mclk);
		i_host_mode <= MODE_PIN;
		i_config_select_pins <= 5'h1a;
		repeat (8) @(posedge i_mclk);
		check({o_spi_sel, o_i2c_sel, o_pin_mode, o_preset_sel}, 8'h3a);
		i_host_mode <= MODE_I2C;
		i_config_select_pins <= 5'h05;
		repeat (8) @(posedge i_mclk);
		check({o_spi_sel, o_i2c_sel, o_pin_mode, o_preset_sel}, 8'h5a);
		i_host_mode <= MODE_SPI;
		repeat (8) @(posedge i_mclk);
		check({o_spi_sel, o_i2c_sel, o_pin_mode, o_preset_sel}, 8'h9a);
		results();
	end

	// run is near 216 us, so 1 ms only trips on a hang
	initial
	begin
		#1000000;
		err_count++;
		results();
	end
endmodule : test_serial_config_port_status
